/* File: rtl/eeprom_ctrl.sv */
// control logic of the byte-alterable nonvolatile array: registers,
// address/data latching, protection interlocks and pump controls;
// assumes cpu-clocked wait/stop/array strobes, special_mode_n from a pin
//
// What this block does
// - wait_clock_stop gates module clock in wait
// - lock bit readable; once normal, free special
// - pump_osc_select picks oscillator, else osc halted
// - protect bits writable only unlocked, no voltage
// - five region bits refuse program and erase
// - test register writable special only, else zero
// - odd/even test bits bulk-select physical rows
// - margin bit puts operations in margin test
// - pump_disable keeps the charge pump off
// - pump_ramp_disable bypasses the controlled ramp
// - pump_monitor routes pump voltage to pin
// - bulk_protect refuses bulk and row erase
// - byte/row select bulk, row or byte erase
// - select bits ignored while erase is clear
// - byte erase acts on latched location only
// - latch_control blocks reads, latches next write
// - voltage enable needs latch already set
// - voltage on freezes control and protect bits
// - voltage on ignores array writes, latches hold
// - select, erase, latch bits writable in any order
// - stop removes voltage, keeps enable, restores after
// - misaligned word latches lower byte only
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module eeprom_ctrl
  import eeprom_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_mode_n,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic arr_wr,
  input wire logic arr_word,
  input wire logic [9:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  output logic arr_read_en,
  output logic [9:0] latched_addr,
  output logic [15:0] latched_data,
  output logic latched_word,
  output logic [1:0] erase_scope,
  output logic hv_request,
  output logic pump_on,
  output logic pump_ramp_en,
  output logic pump_clk_osc,
  output logic osc_run,
  output logic pump_monitor_out,
  output logic margin_test_out,
  output logic odd_row_bulk_out,
  output logic even_row_bulk_out,
  output logic module_clk_en
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // one-hot region of a byte offset, bit i matches region_protect_bits[i]
  function automatic logic [4:0] region_of(input logic [9:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a >= REGION0_BASE && a < ARRAY_END) r[0] = 1'b1;
    else if (a >= REGION1_BASE) r[1] = 1'b1;
    else if (a >= REGION2_BASE) r[2] = 1'b1;
    else if (a >= REGION3_BASE) r[3] = 1'b1;
    else if (a >= REGION4_BASE) r[4] = 1'b1;
    return r;
  endfunction : region_of

  // ----------------------------------------------------------------------
  // mode pin synchroniser
  // ----------------------------------------------------------------------
  logic special_mode_n_meta_r;
  logic special_mode_n_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      special_mode_n_meta_r <= 1'b1;
      special_mode_n_r <= 1'b1;
    end else begin
      special_mode_n_meta_r <= special_mode_n;
      special_mode_n_r <= special_mode_n_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic wait_stop_r;
  logic lock_r;
  logic lock_written_r;
  logic osc_sel_r;
  logic [4:0] bprot_r;
  logic [7:0] test_r;
  logic bulk_protect_r;
  logic byte_r;
  logic row_r;
  logic erase_r;
  logic latch_r;
  logic pgm_r;
  logic latched_valid_r;
  logic [9:0] laddr_r;
  logic [15:0] ldata_r;
  logic lword_r;

  logic wr_cfg;
  logic wr_prot;
  logic wr_test;
  logic wr_prog;
  assign wr_cfg = reg_wr && reg_addr == OFS_MODULE_CONFIG;
  assign wr_prot = reg_wr && reg_addr == OFS_BLOCK_PROTECT;
  assign wr_test = reg_wr && reg_addr == OFS_TEST_CONTROL;
  assign wr_prog = reg_wr && reg_addr == OFS_PROGRAM_CONTROL;

  // module configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_stop_r <= RST_MODULE_CONFIG[BIT_WAIT_CLOCK_STOP];
      osc_sel_r <= RST_MODULE_CONFIG[BIT_PUMP_OSC_SELECT];
      lock_r <= RST_MODULE_CONFIG[BIT_PROTECT_WRITE_LOCK];
      lock_written_r <= 1'b0;
    end else if (wr_cfg) begin
      wait_stop_r <= reg_wdata[BIT_WAIT_CLOCK_STOP];
      osc_sel_r <= reg_wdata[BIT_PUMP_OSC_SELECT];
      // normal modes get a single shot at the lock
      if (!special_mode_n_r || !lock_written_r) begin
        lock_r <= reg_wdata[BIT_PROTECT_WRITE_LOCK];
      end
      if (special_mode_n_r) begin
        lock_written_r <= 1'b1;
      end
    end
  end

  // block protect and bulk protect share one write condition
  logic prot_open;
  assign prot_open = !lock_r && !pgm_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bprot_r <= RST_BLOCK_PROTECT[4:0];
    end else if (wr_prot && prot_open) begin
      bprot_r <= reg_wdata[4:0];
    end
  end

  // test register, cleared whenever the part runs in a normal mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_r <= RST_TEST_CONTROL;
    end else if (special_mode_n_r) begin
      test_r <= 8'h00;
    end else if (wr_test) begin
      test_r <= reg_wdata & MASK_TEST_CONTROL;
    end
  end

  // program control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bulk_protect_r <= RST_PROGRAM_CONTROL[BIT_BULK_PROTECT];
      byte_r <= RST_PROGRAM_CONTROL[BIT_BYTE_SEL];
      row_r <= RST_PROGRAM_CONTROL[BIT_ROW_SEL];
      erase_r <= RST_PROGRAM_CONTROL[BIT_ERASE];
      latch_r <= RST_PROGRAM_CONTROL[BIT_LATCH_CONTROL];
      pgm_r <= RST_PROGRAM_CONTROL[BIT_PROG_VOLTAGE_ENABLE];
    end else if (wr_prog) begin
      if (prot_open) begin
        bulk_protect_r <= reg_wdata[BIT_BULK_PROTECT];
      end
      if (!pgm_r) begin
        byte_r <= reg_wdata[BIT_BYTE_SEL];
        row_r <= reg_wdata[BIT_ROW_SEL];
        erase_r <= reg_wdata[BIT_ERASE];
        latch_r <= reg_wdata[BIT_LATCH_CONTROL];
      end
      // enable only rises on a latch that was set before this write
      pgm_r <= reg_wdata[BIT_PROG_VOLTAGE_ENABLE] && latch_r;
    end
  end

  // ----------------------------------------------------------------------
  // address and data latches
  // ----------------------------------------------------------------------
  logic take_write;
  assign take_write = arr_wr && latch_r && !pgm_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laddr_r <= 10'h000;
      ldata_r <= 16'h0000;
      lword_r <= 1'b0;
      latched_valid_r <= 1'b0;
    end else begin
      if (take_write) begin
        laddr_r <= arr_addr;
        // a misaligned word keeps only its lower byte
        if (arr_word && !arr_addr[0]) begin
          ldata_r <= arr_wdata;
          lword_r <= 1'b1;
        end else begin
          ldata_r <= {8'h00, arr_wdata[7:0]};
          lword_r <= 1'b0;
        end
        latched_valid_r <= 1'b1;
      end else if (!latch_r) begin
        latched_valid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // erase scope and protection
  // ----------------------------------------------------------------------
  scope_type scope;
  always_comb begin
    if (!erase_r) scope = SCOPE_PROGRAM;
    else if (byte_r) scope = SCOPE_BYTE;
    else if (row_r) scope = SCOPE_ROW;
    else scope = SCOPE_BULK;
  end

  logic bulk_rows;
  assign bulk_rows = test_r[BIT_ODD_ROW_BULK] || test_r[BIT_EVEN_ROW_BULK];

  logic [4:0] hit;
  logic refused;
  always_comb begin
    hit = region_of(laddr_r);
    // a bulk operation reaches every region
    if (scope == SCOPE_BULK || bulk_rows) hit = 5'h1f;
    refused = |(hit & bprot_r);
    if (bulk_protect_r && (scope == SCOPE_BULK || scope == SCOPE_ROW)) begin
      refused = 1'b1;
    end
  end

  // stop drops the voltage but leaves the enable bit standing
  logic hv_nxt;
  assign hv_nxt = pgm_r && latched_valid_r && !refused && !stop_mode;

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hv_request <= 1'b0;
      pump_on <= 1'b0;
      pump_ramp_en <= 1'b0;
      pump_clk_osc <= 1'b0;
      osc_run <= 1'b0;
      pump_monitor_out <= 1'b0;
      margin_test_out <= 1'b0;
      odd_row_bulk_out <= 1'b0;
      even_row_bulk_out <= 1'b0;
      module_clk_en <= 1'b1;
      arr_read_en <= 1'b1;
      erase_scope <= SCOPE_PROGRAM;
    end else begin
      hv_request <= hv_nxt;
      pump_on <= hv_nxt && !test_r[BIT_PUMP_DISABLE];
      pump_ramp_en <= !test_r[BIT_PUMP_RAMP_DISABLE];
      pump_clk_osc <= osc_sel_r;
      osc_run <= osc_sel_r && !stop_mode;
      pump_monitor_out <= test_r[BIT_PUMP_MONITOR];
      margin_test_out <= test_r[BIT_MARGIN_TEST];
      odd_row_bulk_out <= test_r[BIT_ODD_ROW_BULK];
      even_row_bulk_out <= test_r[BIT_EVEN_ROW_BULK];
      module_clk_en <= !(wait_mode && wait_stop_r);
      arr_read_en <= !latch_r;
      erase_scope <= scope;
    end
  end

  assign latched_addr = laddr_r;
  assign latched_data = ldata_r;
  assign latched_word = lword_r;

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      OFS_MODULE_CONFIG: begin
        rd_mux[BIT_WAIT_CLOCK_STOP] = wait_stop_r;
        rd_mux[BIT_PROTECT_WRITE_LOCK] = lock_r;
        rd_mux[BIT_PUMP_OSC_SELECT] = osc_sel_r;
      end
      OFS_BLOCK_PROTECT: rd_mux[4:0] = bprot_r;
      OFS_TEST_CONTROL: rd_mux = test_r;
      OFS_PROGRAM_CONTROL: begin
        rd_mux[BIT_BULK_PROTECT] = bulk_protect_r;
        rd_mux[BIT_BYTE_SEL] = byte_r;
        rd_mux[BIT_ROW_SEL] = row_r;
        rd_mux[BIT_ERASE] = erase_r;
        rd_mux[BIT_LATCH_CONTROL] = latch_r;
        rd_mux[BIT_PROG_VOLTAGE_ENABLE] = pgm_r;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_WAIT_GATE: assert property (@(posedge clk) disable iff (rst)
    wait_mode && wait_stop_r |=> !module_clk_en)
    else $error("module clock not gated in wait");
  AST_LOCK_ONCE: assert property (@(posedge clk) disable iff (rst)
    wr_cfg && special_mode_n_r && lock_written_r |=> $stable(lock_r))
    else $error("lock changed by second normal write");
  AST_OSC_SEL: assert property (@(posedge clk) disable iff (rst)
    !osc_sel_r ##1 !osc_sel_r |-> !osc_run && !pump_clk_osc)
    else $error("oscillator runs while not selected");
  AST_PROT_HOLD: assert property (@(posedge clk) disable iff (rst)
    (lock_r || pgm_r) |=> $stable(bprot_r))
    else $error("protect bits moved while frozen");
  AST_REGION_REFUSE: assert property (@(posedge clk) disable iff (rst)
    |(region_of(laddr_r) & bprot_r) |=> !hv_request)
    else $error("voltage on a protected region");
  AST_TEST_ZERO: assert property (@(posedge clk) disable iff (rst)
    special_mode_n_r |=> test_r == 8'h00)
    else $error("test bits set in normal mode");
  AST_PUMP_OFF: assert property (@(posedge clk) disable iff (rst)
    test_r[BIT_PUMP_DISABLE] |=> !pump_on)
    else $error("pump on while disabled");
  AST_BULK_PROT: assert property (@(posedge clk) disable iff (rst)
    bulk_protect_r && erase_r && !byte_r |=> !hv_request)
    else $error("bulk or row erase despite protection");
  AST_READ_BLOCK: assert property (@(posedge clk) disable iff (rst)
    latch_r |=> !arr_read_en)
    else $error("array readable while latched");
  AST_PGM_NEEDS_LATCH: assert property (@(posedge clk) disable iff (rst)
    !latch_r && !pgm_r |=> !pgm_r)
    else $error("enable rose without latch");
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    pgm_r |=> $stable({byte_r, row_r, erase_r, latch_r, bulk_protect_r}))
    else $error("control bits moved under voltage");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
    pgm_r |=> $stable({laddr_r, ldata_r, lword_r}))
    else $error("latches changed under voltage");
  AST_STOP_HV: assert property (@(posedge clk) disable iff (rst)
    stop_mode |=> !hv_request && !osc_run)
    else $error("voltage or oscillator kept in stop");
  AST_MISALIGN: assert property (@(posedge clk) disable iff (rst)
    take_write && arr_word && arr_addr[0] |=> !lword_r && ldata_r[15:8] == 8'h00)
    else $error("misaligned word latched whole");

endmodule : eeprom_ctrl

`default_nettype wire

/* File: rtl/eeprom_ctrl_pkg.sv */
// register map, field positions and reset values of the nonvolatile
// array control block; assumes a byte-wide register port, 2-bit address
package eeprom_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFS_MODULE_CONFIG = 2'h0;
  localparam logic [1:0] OFS_BLOCK_PROTECT = 2'h1;
  localparam logic [1:0] OFS_TEST_CONTROL = 2'h2;
  localparam logic [1:0] OFS_PROGRAM_CONTROL = 2'h3;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  // module_config
  localparam int BIT_WAIT_CLOCK_STOP = 7;
  localparam int BIT_PROTECT_WRITE_LOCK = 1;
  localparam int BIT_PUMP_OSC_SELECT = 0;
  // block_protect: region_protect_bits in 4:0
  localparam int NUM_REGIONS = 5;
  // test_control
  localparam int BIT_ODD_ROW_BULK = 7;
  localparam int BIT_EVEN_ROW_BULK = 6;
  localparam int BIT_MARGIN_TEST = 5;
  localparam int BIT_PUMP_DISABLE = 4;
  localparam int BIT_PUMP_RAMP_DISABLE = 3;
  localparam int BIT_PUMP_MONITOR = 2;
  // program_control
  localparam int BIT_BULK_PROTECT = 7;
  localparam int BIT_BYTE_SEL = 4;
  localparam int BIT_ROW_SEL = 3;
  localparam int BIT_ERASE = 2;
  localparam int BIT_LATCH_CONTROL = 1;
  localparam int BIT_PROG_VOLTAGE_ENABLE = 0;

  // ----------------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_MODULE_CONFIG = 8'h00;
  localparam logic [7:0] RST_BLOCK_PROTECT = 8'h1f;
  localparam logic [7:0] RST_TEST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PROGRAM_CONTROL = 8'h00;
  localparam logic [7:0] MASK_MODULE_CONFIG = 8'h83;
  localparam logic [7:0] MASK_BLOCK_PROTECT = 8'h1f;
  localparam logic [7:0] MASK_TEST_CONTROL = 8'hfc;

  // ----------------------------------------------------------------------
  // array map, byte offsets inside the 768-byte array
  // ----------------------------------------------------------------------
  localparam logic [9:0] REGION4_BASE = 10'h000;
  localparam logic [9:0] REGION3_BASE = 10'h100;
  localparam logic [9:0] REGION2_BASE = 10'h200;
  localparam logic [9:0] REGION1_BASE = 10'h280;
  localparam logic [9:0] REGION0_BASE = 10'h2c0;
  localparam logic [9:0] ARRAY_END = 10'h300;
  localparam int ROW_ADDR_LSB = 5;

  // erase scope driven to the array
  typedef enum logic [1:0] {
    SCOPE_PROGRAM = 2'h0,
    SCOPE_BULK = 2'h1,
    SCOPE_ROW = 2'h2,
    SCOPE_BYTE = 2'h3
  } scope_type;

endpackage : eeprom_ctrl_pkg

/* File: verification/cpu_bus_model.sv */
// cpu model: drives the register port and array writes of the control block
// assumes one clock; the bench calls the tasks, one request at a time
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
  input wire logic clk,
  output logic [1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic arr_wr,
  output logic arr_word,
  output logic [9:0] arr_addr,
  output logic [15:0] arr_wdata
);
  initial begin
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arr_wr = 1'b0;
    arr_word = 1'b0;
    arr_addr = 10'h000;
    arr_wdata = 16'h0000;
  end

  // data lines flip after use so stale values never look valid
  task reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : reg_write

  task reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task arr_write(input logic [9:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    arr_addr <= a;
    arr_word <= w;
    arr_wdata <= d;
    arr_wr <= 1'b1;
    @(posedge clk);
    arr_wr <= 1'b0;
    arr_wdata <= ~d;
  endtask : arr_write
endmodule : cpu_bus_model

`default_nettype wire

/* File: verification/eeprom_program_erase_control_test.sv */
// self-checking bench of the nonvolatile array control block
// assumes cpu_bus_model as register/array master, 4 ns clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module eeprom_program_erase_control_test;
  import eeprom_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic special_mode_n = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic [1:0] reg_addr, erase_scope;
  logic [7:0] reg_wdata, reg_rdata, rd, v;
  logic reg_wr, reg_rd, arr_wr, arr_word, arr_read_en, latched_word;
  logic [9:0] arr_addr, latched_addr, a;
  logic [15:0] arr_wdata, latched_data;
  logic hv_request, pump_on, pump_ramp_en, pump_clk_osc, osc_run;
  logic pump_monitor_out, margin_test_out, odd_row_bulk_out;
  logic even_row_bulk_out, module_clk_en;
  logic [7:0] tst = 8'h00;
  logic [7:0] rst_val [4];
  logic [7:0] pcs [8];
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 12;

  always #2 clk = ~clk;

  cpu_bus_model i_cpu_bus_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_word(arr_word),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata));

  eeprom_ctrl i_eeprom_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode_n(special_mode_n),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .arr_wr(arr_wr),
    .arr_word(arr_word), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_read_en(arr_read_en), .latched_addr(latched_addr),
    .latched_data(latched_data), .latched_word(latched_word),
    .erase_scope(erase_scope), .hv_request(hv_request), .pump_on(pump_on),
    .pump_ramp_en(pump_ramp_en), .pump_clk_osc(pump_clk_osc),
    .osc_run(osc_run), .pump_monitor_out(pump_monitor_out),
    .margin_test_out(margin_test_out), .odd_row_bulk_out(odd_row_bulk_out),
    .even_row_bulk_out(even_row_bulk_out), .module_clk_en(module_clk_en));

  // ----------------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------------
  function automatic logic [1:0] exp_scope(input logic [7:0] pc);
    if (!pc[BIT_ERASE]) return SCOPE_PROGRAM;
    if (pc[BIT_BYTE_SEL]) return SCOPE_BYTE;
    return pc[BIT_ROW_SEL] ? SCOPE_ROW : SCOPE_BULK;
  endfunction : exp_scope

  function automatic logic exp_hv(input logic [4:0] bp, input logic [7:0] pc,
                                  input logic [9:0] adr);
    logic [1:0] s;
    int r;
    s = exp_scope(pc);
    r = adr < REGION3_BASE ? 4 : adr < REGION2_BASE ? 3 :
        adr < REGION1_BASE ? 2 : adr < REGION0_BASE ? 1 : 0;
    if (s == SCOPE_BULK || tst[BIT_ODD_ROW_BULK] || tst[BIT_EVEN_ROW_BULK])
      return bp == 5'h00 && !(s == SCOPE_BULK && pc[BIT_BULK_PROTECT]);
    if (s == SCOPE_ROW && pc[BIT_BULK_PROTECT]) return 1'b0;
    return !bp[r];
  endfunction : exp_hv

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // latch options, write target, raise voltage, then check the interlocks
  task run_op(input logic [4:0] bp, input logic [7:0] pc, input logic [9:0] adr,
              input logic w, input logic [15:0] d);
    logic e;
    e = exp_hv(bp, pc, adr);
    i_cpu_bus_model.reg_write(OFS_BLOCK_PROTECT, {3'h0, bp});
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, pc);
    i_cpu_bus_model.arr_write(adr, w, d);
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, pc | 8'h01);
    settle;
    `CHK(hv_request, e)
    `CHK(pump_on, e & !tst[BIT_PUMP_DISABLE])
    `CHK(erase_scope, exp_scope(pc))
  endtask : run_op

  task finish_op(input logic [7:0] pc);
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, pc & 8'hfe);
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h00);
  endtask : finish_op

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_val = '{RST_MODULE_CONFIG, RST_BLOCK_PROTECT, RST_TEST_CONTROL,
                RST_PROGRAM_CONTROL};
    pcs = '{8'h06, 8'h0e, 8'h16, 8'h1e, 8'h1a, 8'h8e, 8'h86, 8'h96};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      i_cpu_bus_model.reg_read(2'(i), rd);
      `CHK(rd, rst_val[i])
    end
    `CHK(arr_read_en, 1'b1)
    $display("test reset done");

    // test bits, special mode; pump held off during an operation
    tst = 8'hfc;
    i_cpu_bus_model.reg_write(OFS_TEST_CONTROL, tst);
    i_cpu_bus_model.reg_read(OFS_TEST_CONTROL, rd);
    `CHK(rd, 8'hfc)
    `CHK({odd_row_bulk_out, even_row_bulk_out}, 2'h3)
    `CHK(margin_test_out, 1'b1)
    `CHK(pump_ramp_en, 1'b0)
    `CHK(pump_monitor_out, 1'b1)
    run_op(5'h00, 8'h02, 10'h123, 1'b0, 16'h005a);
    finish_op(8'h02);
    tst = 8'h00;
    i_cpu_bus_model.reg_write(OFS_TEST_CONTROL, tst);
    settle;
    `CHK(pump_ramp_en, 1'b1)
    $display("test test_bits done");

    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h81);
    wait_mode <= 1'b1;
    settle;
    `CHK(module_clk_en, 1'b0)
    `CHK({pump_clk_osc, osc_run}, 2'h3)
    stop_mode <= 1'b1;
    settle;
    `CHK(osc_run, 1'b0)
    stop_mode <= 1'b0;
    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h00);
    settle;
    `CHK(module_clk_en, 1'b1)
    `CHK({pump_clk_osc, osc_run}, 2'h0)
    wait_mode <= 1'b0;
    $display("test clocking done");

    // lock set and cleared freely in special mode
    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h02);
    i_cpu_bus_model.reg_write(OFS_BLOCK_PROTECT, 8'h1f);
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h80);
    i_cpu_bus_model.reg_read(OFS_BLOCK_PROTECT, rd);
    `CHK(rd, 8'h00)
    i_cpu_bus_model.reg_read(OFS_PROGRAM_CONTROL, rd);
    `CHK(rd, 8'h00)
    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h00);
    i_cpu_bus_model.reg_read(OFS_MODULE_CONFIG, rd);
    `CHK(rd, 8'h00)
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      i_cpu_bus_model.reg_write(OFS_BLOCK_PROTECT, v);
      i_cpu_bus_model.reg_read(OFS_BLOCK_PROTECT, rd);
      `CHK(rd, v & MASK_BLOCK_PROTECT)
    end
    $display("test lock done");

    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h03);
    i_cpu_bus_model.reg_read(OFS_PROGRAM_CONTROL, rd);
    `CHK(rd, 8'h02)
    for (int i = 0; i < 10; i++) begin
      v = 8'($random(seed));
      a = 10'($unsigned($random(seed)) % 768);
      run_op(v[4:0], 8'h02, a, 1'b0, {8'h00, v});
      `CHK(latched_addr, a)
      `CHK(arr_read_en, 1'b0)
      i_cpu_bus_model.arr_write(a ^ 10'h001, 1'b0, 16'h0055);
      // keep the enable bit high so the freeze is still in force
      i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h9d);
      i_cpu_bus_model.reg_write(OFS_BLOCK_PROTECT, ~v);
      i_cpu_bus_model.reg_read(OFS_PROGRAM_CONTROL, rd);
      `CHK(latched_addr, a)
      `CHK(rd, 8'h03)
      i_cpu_bus_model.reg_read(OFS_BLOCK_PROTECT, rd);
      `CHK(rd, v & MASK_BLOCK_PROTECT)
      i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h02);
    end
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h00);
    settle;
    `CHK(arr_read_en, 1'b1)
    $display("test program done");

    foreach (pcs[i]) begin
      run_op(5'h00, pcs[i], 10'h040, 1'b1, 16'h1234);
      finish_op(pcs[i]);
    end
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h04);
    i_cpu_bus_model.reg_write(OFS_PROGRAM_CONTROL, 8'h06);
    i_cpu_bus_model.reg_read(OFS_PROGRAM_CONTROL, rd);
    `CHK(rd, 8'h06)
    i_cpu_bus_model.arr_write(10'h011, 1'b1, 16'habcd);
    settle;
    `CHK({latched_word, latched_data}, {1'b0, 16'h00cd})
    i_cpu_bus_model.arr_write(10'h010, 1'b1, 16'habcd);
    settle;
    `CHK({latched_word, latched_data}, {1'b1, 16'habcd})
    finish_op(8'h06);
    run_op(5'h00, 8'h02, 10'h100, 1'b0, 16'h0011);
    stop_mode <= 1'b1;
    settle;
    `CHK(hv_request, 1'b0)
    i_cpu_bus_model.reg_read(OFS_PROGRAM_CONTROL, rd);
    `CHK(rd, 8'h03)
    stop_mode <= 1'b0;
    settle;
    `CHK(hv_request, 1'b1)
    finish_op(8'h02);
    $display("test erase done");

    // normal mode: test bits forced low, lock writable once
    special_mode_n <= 1'b1;
    tst = 8'h00;
    repeat (4) @(posedge clk);
    i_cpu_bus_model.reg_write(OFS_TEST_CONTROL, 8'hfc);
    i_cpu_bus_model.reg_read(OFS_TEST_CONTROL, rd);
    `CHK(rd, 8'h00)
    `CHK(margin_test_out, 1'b0)
    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h02);
    i_cpu_bus_model.reg_write(OFS_MODULE_CONFIG, 8'h00);
    i_cpu_bus_model.reg_read(OFS_MODULE_CONFIG, rd);
    `CHK(rd, 8'h02)
    i_cpu_bus_model.reg_write(OFS_BLOCK_PROTECT, 8'h1f);
    i_cpu_bus_model.reg_read(OFS_BLOCK_PROTECT, rd);
    `CHK(rd, 8'h00)
    $display("test normal_mode done");
    close_out;
  end
endmodule : eeprom_program_erase_control_test

`default_nettype wire
